/* rstbod_pkg.sv */
// Package: offsets, field positions, reset values and timing for the block
package rstbod_pkg;
    // Register byte addresses (printed offsets times four)
    localparam logic [7:0] AUX_INDEX = 8'hA2;
    localparam logic [7:0] BOD_INDEX = 8'hA3;
    localparam logic [7:0] IRQ_STATUS_INDEX = 8'hA8;
    localparam logic [7:0] IRQ_MASK_INDEX = 8'hA9;
    localparam logic [7:0] UNLOCK_INDEX = 8'hAA;
    localparam logic [9:0] AUX_ADDR = {AUX_INDEX, 2'b00};
    localparam logic [9:0] BOD_ADDR = {BOD_INDEX, 2'b00};
    localparam logic [9:0] IRQ_STATUS_ADDR = {IRQ_STATUS_INDEX, 2'b00};
    localparam logic [9:0] IRQ_MASK_ADDR = {IRQ_MASK_INDEX, 2'b00};
    localparam logic [9:0] UNLOCK_ADDR = {UNLOCK_INDEX, 2'b00};

    // Auxiliary register fields
    localparam int AUX_SOFTWARE_RESET_FLAG_BIT = 7;
    localparam int AUX_PINF_BIT = 6;
    localparam int AUX_HARD_FAULT_RESET_FLAG_BIT = 5;
    localparam int AUX_GF_BIT = 3;
    localparam int AUX_SWAP_BIT = 2;
    localparam logic [7:0] AUX_WRITE_MASK = 8'hEC;

    // Brown-out control fields
    localparam int BOD_EN_BIT = 7;
    localparam int BOD_TH_HI = 5;
    localparam int BOD_TH_LO = 4;
    localparam int BOD_FLAG_BIT = 3;
    localparam int BOD_RSTEN_BIT = 2;
    localparam int BOD_RSTF_BIT = 1;
    localparam int BOD_STAT_BIT = 0;

    // Configuration byte two fields
    localparam int CFG_EN_BIT = 7;
    localparam int CFG_TH_HI = 5;
    localparam int CFG_TH_LO = 4;
    localparam int CFG_INHIBIT_BIT = 5;
    localparam int CFG_RSTEN_BIT = 2;

    // Interrupt status bits
    localparam int IRQ_BOD_BIT = 0;
    localparam int IRQ_IAP_BIT = 1;
    localparam int IRQ_BROWNOUT_RESET_ENABLE_BIT = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Timed-access unlock key pair
    localparam logic [7:0] UNLOCK_KEY1 = 8'hAA;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h55;
    localparam logic [1:0] UNLOCK_WINDOW = 2'h3;

    // Detector settle: 3 low-speed oscillator edges
    localparam logic [1:0] SETTLE_EDGES = 2'h3;

    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

/* sync_level.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
module sync_level (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic first;
        logic second;
    } sync_s;
    sync_s state_reg;
    sync_s state_next;

    always_comb begin
        state_next.first = din;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dout = state_reg.second;
endmodule // sync_level

/* edge_pulse.sv */
// Rising edge detector on a synchronised level
`timescale 1ns/1ps
module edge_pulse (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic last;
    } edge_s;
    edge_s state_reg;
    edge_s state_next;

    always_comb begin
        state_next.last = level;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rise = level & ~state_reg.last;
    assign fall = ~level & state_reg.last;
endmodule // edge_pulse

/* reset_flags_brownout_control.sv */
// Reset-source flags and brown-out control with APB register access
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps

// Behaviour
// R01: Software reset sets flag bit 7
// R02: Pin reset sets flag bit 6
// R03: PC overflow resets, sets flag bit 5
// R04: Debug with setting 0: flag only
// R05: Bit 3 is free user flag
// R06: Swap bit exchanges serial receive/transmit pins
// R07: Swap applies immediately; avoid mid-transfer
// R08: Bit 1 reads 0; write 0 bit 0
// R09: Enable bit; output valid after settling
// R10: Threshold field selects trip level
// R11: Crossing sets flag; gated interrupt request
// R12: Reset enable gates brown-out reset
// R13: Brown-out reset sets its flag
// R14: Live status read-only, 0 when disabled
// R15: Config byte two reloads settings
// R16: Control writes need timed unlock
// R17: Program below level sets fault flag
// R18: Flags hold until software writes
// R19: Unlock sequence from timed-access scheme
module reset_flags_brownout_control (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic softwareResetCause,
    input wire logic pinResetCause,
    input wire logic brownoutResetCause,
    input wire logic pcOverflow,
    input wire logic debugMode,
    input wire logic debugEnableSetting,
    input wire logic [7:0] configurationByteTwo,
    input wire logic supplyBelowRaw,
    input wire logic lowSpeedOscTick,
    input wire logic programActive,
    input wire logic globalInterruptEnable,
    input wire logic brownoutInterruptEnable,
    input wire logic serialTxData,
    output logic serialRxData,
    input wire logic pinP06In,
    input wire logic pinP07In,
    output logic pinP06Out,
    output logic pinP07Out,
    output logic pinP06Oe,
    output logic pinP07Oe,
    output logic brownoutEnable,
    output logic [1:0] brownoutThresholdSelect,
    output logic hardFaultResetReq,
    output logic brownoutResetReq,
    output logic brownoutIrqReq,
    output logic selfProgramFaultSet,
    output logic irq
);
    typedef struct packed {
        logic loaded;
        logic softwareResetFlag;
        logic pinResetFlag;
        logic hardFaultResetFlag;
        logic userFlagTwo;
        logic serial0PinSwap;
        logic brownoutEnable;
        logic [1:0] brownoutThresholdSelect;
        logic brownoutInterruptFlag;
        logic brownoutResetEnable;
        logic brownoutResetFlag;
        logic [1:0] settleCount;
        logic statusValid;
        logic lastStatus;
        logic [1:0] unlockCount;
        logic unlockFirst;
        logic [2:0] irqStatus;
        logic [2:0] irqMask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic serialRxData;
        logic pinP06Out;
        logic pinP07Out;
        logic pinP06Oe;
        logic pinP07Oe;
        logic hardFaultResetReq;
        logic brownoutResetReq;
        logic brownoutIrqReq;
        logic selfProgramFaultSet;
        logic irq;
    } state_s;

    state_s state_reg;
    state_s state_next;
    logic supplyBelow;
    logic oscLevel;
    logic oscRise;
    logic access;
    logic wrEn;
    logic unlocked;
    logic liveStatus;
    logic crossing;
    logic [7:0] wbyte;
    logic [7:0] auxRead;
    logic [7:0] bodRead;
    logic mapped;

    sync_level supplySync (
        .mclk(mclk),
        .reset_n(reset_n),
        .din(supplyBelowRaw),
        .dout(supplyBelow)
    );

    sync_level oscSync (
        .mclk(mclk),
        .reset_n(reset_n),
        .din(lowSpeedOscTick),
        .dout(oscLevel)
    );

    edge_pulse oscEdge (
        .mclk(mclk),
        .reset_n(reset_n),
        .level(oscLevel),
        .rise(oscRise),
        .fall()
    );

    always_comb begin
        access = psel & penable & ~state_reg.pready;
        wrEn = access & pwrite;
        wbyte = pwdata[7:0];
        unlocked = (state_reg.unlockCount != 2'h0) & ~state_reg.unlockFirst;
        // Status zero while disabled or settling
        liveStatus = state_reg.brownoutEnable & state_reg.statusValid
            & supplyBelow; // [R09] [R14]
        // Disabling drops the status but is no supply crossing
        crossing = state_reg.brownoutEnable & state_reg.statusValid
            & (liveStatus != state_reg.lastStatus); // [R11]
        auxRead = {state_reg.softwareResetFlag, state_reg.pinResetFlag,
            state_reg.hardFaultResetFlag, 1'b0, state_reg.userFlagTwo,
            state_reg.serial0PinSwap, 2'b00}; // [R08]
        bodRead = {state_reg.brownoutEnable, 1'b0,
            state_reg.brownoutThresholdSelect,
            state_reg.brownoutInterruptFlag, state_reg.brownoutResetEnable,
            state_reg.brownoutResetFlag, liveStatus};
        // Upper address bits must be zero
        mapped = (paddr[11:10] == 2'b00) & (paddr[9:0] == rstbod_pkg::AUX_ADDR
            || paddr[9:0] == rstbod_pkg::BOD_ADDR
            || paddr[9:0] == rstbod_pkg::IRQ_STATUS_ADDR
            || paddr[9:0] == rstbod_pkg::IRQ_MASK_ADDR
            || paddr[9:0] == rstbod_pkg::UNLOCK_ADDR);

        state_next = state_reg;
        // Answer one cycle after the take
        state_next.pready = access;
        state_next.pslverr = access & ~mapped;
        state_next.prdata = 32'h0000_0000;

        // Reset-cause capture once after release
        if (!state_reg.loaded) begin
            // Cause inputs name the reset just ended
            state_next.loaded = 1'b1;
            state_next.brownoutEnable =
                configurationByteTwo[rstbod_pkg::CFG_EN_BIT]; // [R15]
            state_next.brownoutThresholdSelect = configurationByteTwo[
                rstbod_pkg::CFG_TH_HI:rstbod_pkg::CFG_TH_LO]; // [R15] [R10]
            state_next.brownoutResetEnable =
                configurationByteTwo[rstbod_pkg::CFG_RSTEN_BIT]; // [R15]
            if (softwareResetCause) begin
                state_next.softwareResetFlag = 1'b1; // [R01]
            end
            if (pinResetCause) begin
                state_next.pinResetFlag = 1'b1; // [R02]
            end
            if (brownoutResetCause) begin
                state_next.brownoutResetFlag = 1'b1; // [R13]
                state_next.irqStatus[rstbod_pkg::IRQ_BROWNOUT_RESET_ENABLE_BIT] = 1'b1;
            end
        end

        // Unlock window counts down
        if (state_reg.unlockCount != 2'h0) begin
            state_next.unlockCount = state_reg.unlockCount - 2'h1;
        end

        // Detector settling on slow oscillator edges
        if (!state_reg.brownoutEnable) begin
            state_next.settleCount = 2'h0;
            state_next.statusValid = 1'b0;
        end else if (oscRise && !state_reg.statusValid) begin
            state_next.settleCount = state_reg.settleCount + 2'h1;
            if (state_reg.settleCount + 2'h1 == rstbod_pkg::SETTLE_EDGES) begin
                state_next.statusValid = 1'b1; // [R09]
            end
        end
        state_next.lastStatus = liveStatus;

        // Register reads; irq status cleared on read
        if (access && !pwrite && mapped) begin
            unique case (paddr[9:0])
                rstbod_pkg::AUX_ADDR: begin
                    state_next.prdata = {24'h0, auxRead};
                end
                rstbod_pkg::BOD_ADDR: begin
                    state_next.prdata = {24'h0, bodRead};
                end
                rstbod_pkg::IRQ_STATUS_ADDR: begin
                    state_next.prdata = {29'h0, state_reg.irqStatus};
                    state_next.irqStatus = rstbod_pkg::IRQ_RESET;
                end
                rstbod_pkg::IRQ_MASK_ADDR: begin
                    state_next.prdata = {29'h0, state_reg.irqMask};
                end
                default: begin
                    state_next.prdata = 32'h0000_0000;
                end
            endcase
        end

        // Register writes
        if (wrEn && mapped) begin
            unique case (paddr[9:0])
                rstbod_pkg::AUX_ADDR: begin
                    state_next.softwareResetFlag =
                        wbyte[rstbod_pkg::AUX_SOFTWARE_RESET_FLAG_BIT]; // [R18]
                    state_next.pinResetFlag = wbyte[rstbod_pkg::AUX_PINF_BIT];
                    state_next.hardFaultResetFlag =
                        wbyte[rstbod_pkg::AUX_HARD_FAULT_RESET_FLAG_BIT];
                    state_next.userFlagTwo = wbyte[rstbod_pkg::AUX_GF_BIT]; // [R05]
                    state_next.serial0PinSwap =
                        wbyte[rstbod_pkg::AUX_SWAP_BIT]; // [R07]
                end
                rstbod_pkg::BOD_ADDR: begin
                    if (unlocked) begin // [R16] [R19]
                        state_next.brownoutEnable =
                            wbyte[rstbod_pkg::BOD_EN_BIT]; // [R09]
                        state_next.brownoutThresholdSelect = wbyte[
                            rstbod_pkg::BOD_TH_HI:rstbod_pkg::BOD_TH_LO];
                        state_next.brownoutInterruptFlag =
                            wbyte[rstbod_pkg::BOD_FLAG_BIT]; // [R18]
                        state_next.brownoutResetEnable =
                            wbyte[rstbod_pkg::BOD_RSTEN_BIT]; // [R12]
                        state_next.brownoutResetFlag =
                            wbyte[rstbod_pkg::BOD_RSTF_BIT]; // [R18]
                    end
                    state_next.unlockCount = 2'h0;
                end
                rstbod_pkg::IRQ_MASK_ADDR: state_next.irqMask = wbyte[2:0];
                rstbod_pkg::UNLOCK_ADDR: begin
                    // Two keys back to back open a short window
                    if (wbyte == rstbod_pkg::UNLOCK_KEY1) begin // [R19]
                        state_next.unlockFirst = 1'b1;
                        state_next.unlockCount = rstbod_pkg::UNLOCK_WINDOW;
                    end else if (wbyte == rstbod_pkg::UNLOCK_KEY2
                        && state_reg.unlockFirst
                        && state_reg.unlockCount != 2'h0) begin
                        state_next.unlockFirst = 1'b0;
                        state_next.unlockCount = rstbod_pkg::UNLOCK_WINDOW;
                    end else begin
                        state_next.unlockFirst = 1'b0;
                        state_next.unlockCount = 2'h0;
                    end
                end
                default: state_next.unlockCount = state_next.unlockCount;
            endcase
        end else if (state_reg.unlockCount == 2'h1) begin
            state_next.unlockFirst = 1'b0;
        end

        // Hardware sets win over software clears
        if (pcOverflow) begin
            state_next.hardFaultResetFlag = 1'b1; // [R03] [R04]
        end
        if (crossing) begin
            state_next.brownoutInterruptFlag = 1'b1; // [R11]
            state_next.irqStatus[rstbod_pkg::IRQ_BOD_BIT] = 1'b1;
        end
        // Fault only while the inhibit bit is left at 1
        state_next.selfProgramFaultSet = programActive & liveStatus
            & state_reg.brownoutEnable & ~state_reg.brownoutResetEnable
            & configurationByteTwo[rstbod_pkg::CFG_INHIBIT_BIT]; // [R17]
        if (state_next.selfProgramFaultSet) begin
            state_next.irqStatus[rstbod_pkg::IRQ_IAP_BIT] = 1'b1;
        end

        // Reset requests toward the system reset controller
        state_next.hardFaultResetReq = pcOverflow
            & ~(debugMode & ~debugEnableSetting); // [R03] [R04]
        state_next.brownoutResetReq = liveStatus
            & state_reg.brownoutResetEnable; // [R12]
        state_next.brownoutIrqReq = state_next.brownoutInterruptFlag
            & brownoutInterruptEnable & globalInterruptEnable; // [R11]

        // Serial pin routing; receive pin is input only
        if (state_reg.serial0PinSwap) begin // [R06] [R07]
            state_next.serialRxData = pinP06In;
            state_next.pinP07Out = serialTxData;
            state_next.pinP07Oe = 1'b1;
            state_next.pinP06Out = 1'b0;
            state_next.pinP06Oe = 1'b0;
        end else begin
            state_next.serialRxData = pinP07In;
            state_next.pinP06Out = serialTxData;
            state_next.pinP06Oe = 1'b1;
            state_next.pinP07Out = 1'b0;
            state_next.pinP07Oe = 1'b0;
        end

        // Level output while any unmasked bit is set
        state_next.irq = |(state_next.irqStatus & state_reg.irqMask);
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign serialRxData = state_reg.serialRxData;
    assign pinP06Out = state_reg.pinP06Out;
    assign pinP07Out = state_reg.pinP07Out;
    assign pinP06Oe = state_reg.pinP06Oe;
    assign pinP07Oe = state_reg.pinP07Oe;
    assign brownoutEnable = state_reg.brownoutEnable;
    assign brownoutThresholdSelect = state_reg.brownoutThresholdSelect;
    assign hardFaultResetReq = state_reg.hardFaultResetReq;
    assign brownoutResetReq = state_reg.brownoutResetReq;
    assign brownoutIrqReq = state_reg.brownoutIrqReq;
    assign selfProgramFaultSet = state_reg.selfProgramFaultSet;
    assign irq = state_reg.irq;
endmodule // reset_flags_brownout_control

/* reset_flags_brownout_control_checker.sv */
// Checker: port assertions for the reset flag and brown-out block
`timescale 1ns/1ps
module reset_flags_brownout_control_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic pcOverflow,
    input wire logic debugMode,
    input wire logic debugEnableSetting,
    input wire logic [7:0] configurationByteTwo,
    input wire logic programActive,
    input wire logic globalInterruptEnable,
    input wire logic brownoutInterruptEnable,
    input wire logic serialTxData,
    input wire logic serialRxData,
    input wire logic pinP06In,
    input wire logic pinP07In,
    input wire logic pinP06Out,
    input wire logic pinP06Oe,
    input wire logic pinP07Oe,
    input wire logic brownoutEnable,
    input wire logic [1:0] brownoutThresholdSelect,
    input wire logic hardFaultResetReq,
    input wire logic brownoutResetReq,
    input wire logic brownoutIrqReq,
    input wire logic selfProgramFaultSet
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_rx_plain; (pinP06Oe && $stable(pinP07In))[*3]; endsequence
    sequence s_rx_swap; (pinP07Oe && $stable(pinP06In))[*3]; endsequence
    sequence s_tx_plain; (pinP06Oe && $stable(serialTxData))[*3]; endsequence

    property p_hard_req;
        pcOverflow && !(debugMode && !debugEnableSetting) |=> hardFaultResetReq;
    endproperty
    a_hard_req: assert property (p_hard_req)
        else $error("hard fault request missing");
    property p_debug_block;
        debugMode && !debugEnableSetting |=> !hardFaultResetReq;
    endproperty
    a_debug_block: assert property (p_debug_block)
        else $error("hard fault request not suppressed in debug");
    property p_rx_plain; s_rx_plain |-> serialRxData == pinP07In; endproperty
    a_rx_plain: assert property (p_rx_plain)
        else $error("receive not taken from P0.7");
    property p_rx_swap; s_rx_swap |-> serialRxData == pinP06In; endproperty
    a_rx_swap: assert property (p_rx_swap)
        else $error("receive not taken from P0.6 when swapped");
    property p_tx_plain; s_tx_plain |-> pinP06Out == serialTxData; endproperty
    a_tx_plain: assert property (p_tx_plain)
        else $error("transmit not on P0.6");
    property p_irq_gate;
        brownoutIrqReq |->
            $past(globalInterruptEnable) && $past(brownoutInterruptEnable);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("brown-out request without both enables");
    property p_rst_gate;
        brownoutResetReq |-> brownoutEnable || $past(brownoutEnable);
    endproperty
    a_rst_gate: assert property (p_rst_gate)
        else $error("brown-out reset with detector off");
    property p_prog_fault;
        selfProgramFaultSet |-> $past(programActive)
            || $past(programActive, 2);
    endproperty
    a_prog_fault: assert property (p_prog_fault)
        else $error("program fault without programming");
    property p_load;
        $rose(reset_n) |-> ##2
            brownoutEnable == $past(configurationByteTwo[7], 2) &&
            brownoutThresholdSelect == $past(configurationByteTwo[5:4], 2);
    endproperty
    a_load: assert property (p_load)
        else $error("settings not loaded after reset");
endmodule // reset_flags_brownout_control_checker

bind reset_flags_brownout_control reset_flags_brownout_control_checker chk (
    .mclk, .reset_n, .pcOverflow, .debugMode, .debugEnableSetting,
    .configurationByteTwo, .programActive, .globalInterruptEnable,
    .brownoutInterruptEnable, .serialTxData, .serialRxData, .pinP06In,
    .pinP07In, .pinP06Out, .pinP06Oe, .pinP07Oe, .brownoutEnable,
    .brownoutThresholdSelect, .hardFaultResetReq, .brownoutResetReq,
    .brownoutIrqReq, .selfProgramFaultSet);

/* reset_flags_brownout_control_tb_top.sv */
// Testbench: random and corner stimulus for the reset flag block
`timescale 1ns/1ps
module reset_flags_brownout_control_tb_top;
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic softwareResetCause, pinResetCause, brownoutResetCause;
    logic pcOverflow, debugMode, debugEnableSetting, supplyBelowRaw;
    logic [7:0] configurationByteTwo, cfg, v;
    logic lowSpeedOscTick, programActive, globalInterruptEnable;
    logic brownoutInterruptEnable, serialTxData, serialRxData;
    logic pinP06In, pinP07In, pinP06Out, pinP07Out, pinP06Oe, pinP07Oe;
    logic brownoutEnable, hardFaultResetReq, brownoutResetReq;
    logic brownoutIrqReq, selfProgramFaultSet, irq;
    logic [1:0] brownoutThresholdSelect;
    logic [2:0] tickDiv;
    logic [3:0] pinView;
    int badCount, checkCount;
    localparam logic [11:0] AUX = {2'h0, rstbod_pkg::AUX_ADDR};
    localparam logic [11:0] BOD = {2'h0, rstbod_pkg::BOD_ADDR};
    localparam logic [11:0] STA = {2'h0, rstbod_pkg::IRQ_STATUS_ADDR};
    localparam logic [11:0] MSK = {2'h0, rstbod_pkg::IRQ_MASK_ADDR};
    localparam logic [11:0] ULK = {2'h0, rstbod_pkg::UNLOCK_ADDR};

    reset_flags_brownout_control dut (.*);

    assign pinView = {serialRxData, pinP07Oe ? pinP07Out : pinP06Out,
        pinP06Oe, pinP07Oe};
    always #20 mclk = ~mclk;
    // Free-running slow oscillator, eight clocks a period
    always @(posedge mclk) begin
        tickDiv <= tickDiv + 3'h1;
        lowSpeedOscTick <= tickDiv[2];
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finalReport();
        if (badCount == 0 && checkCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One transfer; psel stays high so another may follow at once
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [7:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
    endtask
    task automatic idle();
        psel <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
        idle();
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        idle();
        chk(rd, {24'h0, e});
    endtask
    task automatic ulk(input logic [7:0] d);
        apb(1'b1, ULK, rstbod_pkg::UNLOCK_KEY1);
        apb(1'b1, ULK, rstbod_pkg::UNLOCK_KEY2);
        wr(BOD, d);
    endtask
    task automatic rst(input logic [7:0] c, input logic [2:0] cause);
        reset_n <= 1'b0;
        configurationByteTwo <= c;
        {softwareResetCause, pinResetCause, brownoutResetCause} <= cause;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask
    function automatic logic [7:0] bod_exp(input logic [7:0] c, input logic f);
        return {c[7], 1'b0, c[5:4], 1'b0, c[2], f, 1'b0};
    endfunction
    function automatic logic [3:0] swap_exp(input logic s,
            input logic [2:0] p);
        return {s ? p[2] : p[1], p[0], ~s, s};
    endfunction

    initial begin
        repeat (20000) @(posedge mclk);
        chk(32'h0, 32'h1);
        finalReport();
    end

    initial begin
        {mclk, reset_n, psel, penable, pwrite, pcOverflow} = '0;
        {debugMode, debugEnableSetting, supplyBelowRaw, programActive} = '0;
        {softwareResetCause, pinResetCause, brownoutResetCause} = '0;
        {globalInterruptEnable, brownoutInterruptEnable, serialTxData} = '0;
        {pinP06In, pinP07In, lowSpeedOscTick, tickDiv} = '0;
        {paddr, pwdata, configurationByteTwo} = '0;
        badCount = 0;
        checkCount = 0;
        void'($urandom(63));
        @(posedge mclk);
        for (int i = 0; i < 3; i++) begin
            cfg = 8'($urandom()) & 8'hDF;
            v = (i == 0) ? 8'h07 : 8'($urandom());
            rst(cfg, v[2:0]);
            rdchk(AUX, {v[2], v[1], 6'h00});
            rdchk(BOD, bod_exp(cfg, v[0]));
        end
        wr(BOD, ~bod_exp(cfg, 1'b0));
        rdchk(BOD, bod_exp(cfg, v[0]));
        apb(1'b0, 12'h000, 8'h00);
        idle();
        chk(err, 1'b1);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hFE : (i == 1) ? 8'h00 : 8'($urandom() & 32'hFE);
            wr(AUX, v);
            rdchk(AUX, v & 8'hEC);
        end
        for (int s = 0; s < 2; s++) begin
            wr(AUX, {5'h00, s[0], 2'h0});
            for (int k = 0; k < 4; k++) begin
                v = 8'($urandom());
                {pinP06In, pinP07In, serialTxData} <= v[2:0];
                wait_n(3);
                chk(pinView, swap_exp(s[0], v[2:0]));
            end
        end
        for (int i = 0; i < 4; i++) begin
            wr(AUX, 8'h00);
            {debugMode, debugEnableSetting} <= i[1:0];
            pcOverflow <= 1'b1;
            @(posedge mclk);
            pcOverflow <= 1'b0;
            @(posedge mclk);
            chk(hardFaultResetReq, i != 2);
            rdchk(AUX, 8'h20);
        end
        for (int t = 0; t < 4; t++) begin
            ulk({2'h0, t[1:0], 4'h0});
            chk(brownoutThresholdSelect, t[1:0]);
            rdchk(BOD, {2'h0, t[1:0], 4'h0});
        end
        apb(1'b0, STA, 8'h00);
        ulk(8'h80);
        chk(brownoutEnable, 1'b1);
        wait_n(60);
        supplyBelowRaw <= 1'b1;
        wait_n(8);
        rdchk(BOD, 8'h89);
        rdchk(STA, 8'h01);
        rdchk(STA, 8'h00);
        programActive <= 1'b1;
        wait_n(4);
        chk(selfProgramFaultSet, 1'b0);
        configurationByteTwo[rstbod_pkg::CFG_INHIBIT_BIT] <= 1'b1;
        wait_n(4);
        chk(selfProgramFaultSet, 1'b1);
        programActive <= 1'b0;
        wait_n(4);
        rdchk(STA, 8'h02);
        wr(MSK, 8'h01);
        supplyBelowRaw <= 1'b0;
        wait_n(8);
        chk(irq, 1'b1);
        chk(brownoutIrqReq, 1'b0);
        {globalInterruptEnable, brownoutInterruptEnable} <= 2'h3;
        wait_n(3);
        chk(brownoutIrqReq, 1'b1);
        rdchk(STA, 8'h01);
        chk(irq, 1'b0);
        globalInterruptEnable <= 1'b0;
        wr(MSK, 8'h00);
        supplyBelowRaw <= 1'b1;
        wait_n(8);
        chk(irq, 1'b0);
        chk(brownoutIrqReq, 1'b0);
        ulk(8'h84);
        wait_n(4);
        chk(brownoutResetReq, 1'b1);
        rdchk(BOD, 8'h85);
        ulk(8'h80);
        wait_n(3);
        chk(brownoutResetReq, 1'b0);
        ulk(8'h00);
        wait_n(4);
        rdchk(BOD, 8'h00);
        chk(brownoutEnable, 1'b0);
        finalReport();
    end
endmodule // reset_flags_brownout_control_tb_top
